// ---- design/scs_cfg.svh ----
// Constants for the switching clock select and sync block
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
`define SCS_CLK_HZ        125000000
`define SCS_BASE_HZ       8000000
`define SCS_N_MIN         8
`define SCS_N_MAX         40
`define SCS_N_400K        20
`define SCS_N_200K        40
`define SCS_N_1M          8
`define SCS_EXT_MIN_HZ    200000
`define SCS_EXT_MAX_HZ    1000000
// Ticks of clk per base tick (125 MHz / 8 MHz, rounded down)
`define SCS_TICK_DIV      15
// Missing clock timeout: two slowest periods of 5 us, in cycles
`define SCS_LOSS_NS       10000
`define SCS_LOSS_CYC      ((`SCS_LOSS_NS * (`SCS_CLK_HZ / 1000000)) / 1000)
// Search window after enable: slowest period 5 us times four
`define SCS_DET_NS        20000
`define SCS_DET_CYC       ((`SCS_DET_NS * (`SCS_CLK_HZ / 1000000)) / 1000)
// Edges needed to declare a valid clock
`define SCS_LOCK_EDGES    3
`endif

// ---- design/scs_nco.sv ----
// Divider that turns the base tick into the switching clock
`timescale 1ns/1ns
`default_nettype none
`include "scs_cfg.svh"
module scs_nco
  import scs_pkg::*;
#(
  parameter int DW = 6
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Control
  input  wire logic [DW-1:0] div_n,
  input  wire logic          realign,
  // Output
  output logic               sw_clk,
  output logic               sw_pulse
);
  initial begin
    if (DW < 6) $error("scs_nco: DW too small for divisor 40");
  end
  logic [3:0]    pre_reg, pre_next;
  logic [DW-1:0] cnt_reg, cnt_next;
  logic          clk_reg, clk_next;
  logic          pls_reg, pls_next;
  // Prescaler to 8 MHz then count N ticks; realign restarts period
  always_comb begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    clk_next = clk_reg;
    pls_next = 1'b0;
    if (realign) begin
      pre_next = 4'h0;
      cnt_next = '0;
      clk_next = 1'b1;
      pls_next = 1'b1;
    end else if (pre_reg == 4'(`SCS_TICK_DIV - 1)) begin
      pre_next = 4'h0;
      if (cnt_reg >= div_n - DW'(1)) begin
        cnt_next = '0;
        clk_next = 1'b1;
        pls_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + DW'(1);
        if (cnt_reg + DW'(1) == (div_n >> 1)) clk_next = 1'b0;
      end
    end else begin
      pre_next = pre_reg + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_reg <= 4'h0;
      cnt_reg <= '0;
      clk_reg <= 1'b0;
      pls_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
      pls_reg <= pls_next;
    end
  end
  assign sw_clk   = clk_reg;
  assign sw_pulse = pls_reg;
endmodule
`default_nettype wire

// ---- design/scs_pkg.sv ----
// Types for the switching clock select and sync block
package scs_pkg;
  // Strap modes of the configuration pin
  typedef enum logic [1:0] {
    SCS_CFG_IN   = 2'b00,
    SCS_CFG_AUTO = 2'b01,
    SCS_CFG_OUT  = 2'b10
  } scs_cfg_e;
  // Strap states: three pin levels plus resistor
  typedef enum logic [1:0] {
    SCS_PIN_LOW  = 2'b00,
    SCS_PIN_OPEN = 2'b01,
    SCS_PIN_HIGH = 2'b10,
    SCS_PIN_RES  = 2'b11
  } scs_strap_e;
  // Top-level states
  typedef enum logic [2:0] {
    SCS_ST_IDLE   = 3'b000,
    SCS_ST_SEARCH = 3'b001,
    SCS_ST_LOCKED = 3'b010,
    SCS_ST_FREE   = 3'b011,
    SCS_ST_HOLD   = 3'b100
  } scs_state_e;
endpackage

// ---- design/scs_top.sv ----
// Switching clock mode select, external sync detect and frequency choice
`timescale 1ns/1ns
`default_nettype none
`include "scs_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Output mode drives internal 400kHz onto pin
// - Output mode ignores the shared pin
// - Input mode searches for clock each enable
// - Input mode locks to external rising edges
// - Lost clock: hold last frequency internally
// - Auto mode locks if valid clock found
// - Auto no clock: strap low/open/high frequency
// - Resistor strap maps seventeen steps to frequency
// - Auto strap sampled only at start-up
// - Bus frequency is 8MHz over N, 8..40
// - Nearest valid divisor chosen
// - Readback reports the quantized frequency
module scs_top
  import scs_pkg::*;
#(
  parameter int DW       = 6,
  parameter int LOSS_CYC = `SCS_LOSS_CYC,
  parameter int DET_CYC  = `SCS_DET_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Straps and enable (from pins)
  input  wire logic [1:0]  cfg_strap,
  input  wire logic [1:0]  sync_strap,
  input  wire logic [4:0]  res_step,
  input  wire logic        enable,
  // Shared clock pin
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe,
  // Management bus frequency request, kHz
  input  wire logic        freq_wr,
  input  wire logic [10:0] freq_khz,
  // Status and switching clock
  output logic [DW-1:0]    div_n_out,
  output logic [10:0]      freq_rd_khz,
  output logic             locked,
  output logic             sw_clk
);
  initial begin
    if (DW < 6) $error("scs_top: DW too small");
    if (LOSS_CYC < 1 || DET_CYC < LOSS_CYC) $error("scs_top: bad timeouts");
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage is read only by the second. Left
  // unreset so the straps have settled by the time reset lets go.
  logic [10:0] s1_reg, s2_reg;
  logic        sync_d_reg;
  always_ff @(posedge clk) begin
    s1_reg <= {sync_in, enable, cfg_strap, sync_strap, res_step};
    s2_reg <= s1_reg;
  end
  // Previous synced pin level, idle low like the pin, for edge detection
  always_ff @(posedge clk) begin
    if (reset) sync_d_reg <= 1'b0;
    else sync_d_reg <= s2_reg[10];
  end
  logic sync_s, en_s;
  logic [1:0] cfg_s, strap_s;
  logic [4:0] res_s;
  assign sync_s  = s2_reg[10];
  assign en_s    = s2_reg[9];
  assign cfg_s   = s2_reg[8:7];
  assign strap_s = s2_reg[6:5];
  assign res_s   = s2_reg[4:0];
  logic sync_rise;
  assign sync_rise = sync_s & ~sync_d_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // Resistor step to divisor table (17 steps, 200 kHz to 1000 kHz)
  function automatic logic [DW-1:0] res_div(input logic [4:0] step);
    logic [DW-1:0] d;
    d = DW'(`SCS_N_400K);
    case (step)
      5'd0:    d = DW'(40);
      5'd1:    d = DW'(36);
      5'd2:    d = DW'(33);
      5'd3:    d = DW'(30);
      5'd4:    d = DW'(27);
      5'd5:    d = DW'(25);
      5'd6:    d = DW'(22);
      5'd7:    d = DW'(20);
      5'd8:    d = DW'(19);
      5'd9:    d = DW'(17);
      5'd10:   d = DW'(15);
      5'd11:   d = DW'(14);
      5'd12:   d = DW'(13);
      5'd13:   d = DW'(12);
      5'd14:   d = DW'(11);
      5'd15:   d = DW'(9);
      5'd16:   d = DW'(8);
      default: d = DW'(`SCS_N_400K);
    endcase
    return d;
  endfunction
  // Divisor whose frequency lies nearest a kHz request, clamped to range
  function automatic logic [DW-1:0] req_div(input logic [10:0] f);
    logic [31:0] lo;
    logic [31:0] q;
    lo = 32'd0;
    q  = 32'd0;
    if (f <= 11'd200) begin
      q = 32'(`SCS_N_MAX);
    end else if (f >= 11'd1000) begin
      q = 32'(`SCS_N_MIN);
    end else begin
      // Frequency midpoint, not period midpoint: keep lo when 8000/lo is nearer
      lo = 32'd8000 / 32'(f);
      if (32'd8000 * (32'd2 * lo + 32'd1) <= 32'd2 * 32'(f) * lo * (lo + 32'd1)) q = lo;
      else q = lo + 32'd1;
    end
    return q[DW-1:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Control state
  scs_state_e          st_reg, st_next;
  logic                en_d_reg, en_d_next;
  logic                strap_done_reg, strap_done_next;
  logic [DW-1:0]       strap_n_reg, strap_n_next;
  logic [DW-1:0]       div_reg, div_next;
  logic [15:0]         tmr_reg, tmr_next;
  logic [15:0]         per_reg, per_next;
  logic [1:0]          edges_reg, edges_next;
  logic                lock_reg, lock_next;
  logic                oe_reg, oe_next;
  logic                realign;
  logic [10:0]         rd_reg, rd_next;
  logic [DW-1:0]       meas_n;
  logic [31:0]         meas_q;
  // Measured period in 8 MHz ticks, rounded to nearest divisor; clamped
  // so a clock outside the permitted range still gives a legal divisor
  always_comb begin
    meas_q = (32'(per_reg) + 32'd7) / 32'(`SCS_TICK_DIV);
    if (meas_q < 32'(`SCS_N_MIN)) meas_q = 32'(`SCS_N_MIN);
    if (meas_q > 32'(`SCS_N_MAX)) meas_q = 32'(`SCS_N_MAX);
    meas_n = meas_q[DW-1:0];
  end
  // Mode sequencing and external clock tracking
  always_comb begin
    st_next         = st_reg;
    en_d_next       = en_s;
    strap_done_next = strap_done_reg;
    strap_n_next    = strap_n_reg;
    div_next        = div_reg;
    tmr_next        = tmr_reg;
    per_next        = per_reg;
    edges_next      = edges_reg;
    lock_next       = 1'b0;
    oe_next         = 1'b0;
    realign         = 1'b0;
    if (tmr_reg != 16'hffff) tmr_next = tmr_reg + 16'h0001;
    // Strap caught once after reset release only
    if (!strap_done_reg) begin
      strap_done_next = 1'b1;
      case (strap_s)
        SCS_PIN_LOW:  strap_n_next = DW'(`SCS_N_200K);
        SCS_PIN_OPEN: strap_n_next = DW'(`SCS_N_400K);
        SCS_PIN_HIGH: strap_n_next = DW'(`SCS_N_1M);
        default:      strap_n_next = res_div(res_s);
      endcase
    end
    case (st_reg)
      SCS_ST_IDLE: begin
        if (cfg_s == SCS_CFG_OUT) begin
          st_next  = SCS_ST_FREE;
          div_next = DW'(`SCS_N_400K);
        end else if (en_s && !en_d_reg) begin
          st_next    = SCS_ST_SEARCH;
          tmr_next   = 16'h0000;
          edges_next = 2'd0;
        end
      end
      SCS_ST_SEARCH: begin
        // Needs a steady clock at enable; edges counted over the window
        if (sync_rise) begin
          per_next = tmr_reg;
          tmr_next = 16'h0000;
          if (edges_reg != 2'd0 && tmr_reg <= 16'(LOSS_CYC)) begin
            edges_next = edges_reg + 2'd1;
          end else begin
            edges_next = 2'd1;
          end
          if (edges_reg == 2'(`SCS_LOCK_EDGES - 1) && tmr_reg <= 16'(LOSS_CYC)) begin
            st_next = SCS_ST_LOCKED;
            realign = 1'b1;
          end
        end else if (tmr_reg >= 16'(DET_CYC) || !en_s) begin
          st_next = SCS_ST_FREE;
          if (cfg_s == SCS_CFG_AUTO) div_next = strap_n_reg;
        end
      end
      SCS_ST_LOCKED: begin
        lock_next = 1'b1;
        div_next  = meas_n;
        if (sync_rise) begin
          per_next = tmr_reg;
          tmr_next = 16'h0000;
          realign  = 1'b1;
        end else if (tmr_reg >= 16'(LOSS_CYC)) begin
          st_next   = SCS_ST_HOLD;
          lock_next = 1'b0;
        end
        if (!en_s) st_next = SCS_ST_IDLE;
      end
      SCS_ST_HOLD: begin
        // Free run at the last measured divisor until next enable
        if (!en_s) st_next = SCS_ST_IDLE;
      end
      SCS_ST_FREE: begin
        if (cfg_s == SCS_CFG_OUT) begin
          oe_next  = 1'b1;
          div_next = DW'(`SCS_N_400K);
        end else if (!en_s) begin
          st_next = SCS_ST_IDLE;
        end
      end
      default: st_next = SCS_ST_IDLE;
    endcase
    // Bus request overrides the divisor outside lock and output mode
    if (freq_wr && st_next != SCS_ST_LOCKED && cfg_s != SCS_CFG_OUT) begin
      div_next = req_div(freq_khz);
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg         <= SCS_ST_IDLE;
      en_d_reg       <= 1'b0;
      strap_done_reg <= 1'b0;
      strap_n_reg    <= DW'(`SCS_N_400K);
      div_reg        <= DW'(`SCS_N_400K);
      tmr_reg        <= 16'h0000;
      per_reg        <= 16'h0000;
      edges_reg      <= 2'd0;
      lock_reg       <= 1'b0;
      oe_reg         <= 1'b0;
    end else begin
      st_reg         <= st_next;
      en_d_reg       <= en_d_next;
      strap_done_reg <= strap_done_next;
      strap_n_reg    <= strap_n_next;
      div_reg        <= div_next;
      tmr_reg        <= tmr_next;
      per_reg        <= per_next;
      edges_reg      <= edges_next;
      lock_reg       <= lock_next;
      oe_reg         <= oe_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Readback of the quantized frequency, kHz = 8000 / N
  always_comb begin
    rd_next = 11'((32'd8000 + 32'(div_reg >> 1)) / 32'(div_reg));
  end
  always_ff @(posedge clk) begin
    if (reset) rd_reg <= 11'd400;
    else rd_reg <= rd_next;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Switching clock generator
  logic nco_clk;
  scs_nco #(.DW(DW)) u_nco (
    .clk      (clk),
    .reset    (reset),
    .div_n    (div_reg),
    .realign  (realign),
    .sw_clk   (nco_clk),
    .sw_pulse ()
  );
  logic sw_reg;
  always_ff @(posedge clk) begin
    if (reset) sw_reg <= 1'b0;
    else sw_reg <= nco_clk;
  end
  assign sync_out    = sw_reg;
  assign sync_oe     = oe_reg;
  assign sw_clk      = sw_reg;
  assign locked      = lock_reg;
  assign div_n_out   = div_reg;
  assign freq_rd_khz = rd_reg;
endmodule
`default_nettype wire

// ---- verif/scs_src_model.sv ----
// Far-side clock source that drives the shared clock pin
`timescale 1ns/1ns
`default_nettype none
module scs_src_model #(
  parameter int HALF_NS = 80
) (
  // Control from the bench
  input  wire logic run,
  // Pin drive
  output logic      clk_out
);
  // Gated source: stands low outside bursts, already running before enable
  initial begin
    clk_out = 1'b0;
    forever begin
      #HALF_NS;
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/scs_top_assertions.sv ----
// Port-level checks for the clock select and sync block
`timescale 1ns/1ns
`default_nettype none
`include "scs_cfg.svh"
module scs_top_assertions #(
  parameter int DW       = 6,
  parameter int LOSS_CYC = `SCS_LOSS_CYC,
  parameter int DET_CYC  = `SCS_DET_CYC
) (
  // Clock and reset
  input wire logic          clk,
  input wire logic          reset,
  // Pin and bus side
  input wire logic          enable,
  input wire logic          sync_in,
  input wire logic          sync_out,
  input wire logic          sync_oe,
  input wire logic          freq_wr,
  input wire logic [10:0]   freq_khz,
  // Status
  input wire logic [DW-1:0] div_n_out,
  input wire logic [10:0]   freq_rd_khz,
  input wire logic          locked,
  input wire logic          sw_clk
);
  logic [15:0] still_reg, still_next;
  logic        last_reg;
  // Divisor whose frequency lies nearest the request, by search over all N
  function automatic int n_of(input int f);
    int best;
    best = `SCS_N_MIN;
    if (f <= `SCS_EXT_MIN_HZ / 1000) return `SCS_N_MAX;
    if (f >= `SCS_EXT_MAX_HZ / 1000) return `SCS_N_MIN;
    for (int n = `SCS_N_MIN + 1; n <= `SCS_N_MAX; n++) begin
      int dn;
      int db;
      // Distances compared cross-multiplied to stay in integers
      dn = `SCS_BASE_HZ / 1000 - f * n;
      db = `SCS_BASE_HZ / 1000 - f * best;
      if (dn < 0) dn = -dn;
      if (db < 0) db = -db;
      if (dn * best < db * n) best = n;
    end
    return best;
  endfunction
  ////////////////////////////////////////
  // Cycles since the pin last moved, saturating so it never wraps
  always_comb begin
    still_next = (sync_in != last_reg) ? 16'h0000 : still_reg + {15'h0000, still_reg != 16'hffff};
  end
  always_ff @(posedge clk) begin
    last_reg  <= sync_in;
    still_reg <= reset ? 16'h0000 : still_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_req;
    freq_wr && !locked && !sync_oe;
  endsequence
  property p_bus_n;
    s_req |=> div_n_out == n_of($past(freq_khz));
  endproperty
  a_bus_n: assert property (p_bus_n) else $error("divisor differs from request");
  property p_div_rng;
    div_n_out >= `SCS_N_MIN && div_n_out <= `SCS_N_MAX;
  endproperty
  a_div_rng: assert property (p_div_rng) else $error("divisor out of range");
  property p_rd_q;
    $stable(div_n_out) |-> freq_rd_khz * div_n_out > 8000 - div_n_out
      && freq_rd_khz * div_n_out < 8000 + div_n_out;
  endproperty
  a_rd_q: assert property (p_rd_q) else $error("readback not quantized");
  property p_out_400k;
    sync_oe |-> div_n_out == `SCS_N_400K;
  endproperty
  a_out_400k: assert property (p_out_400k) else $error("output mode rate wrong");
  property p_out_drv;
    sync_oe |-> ##[1:400] $changed(sync_out);
  endproperty
  a_out_drv: assert property (p_out_drv) else $error("pin not driven");
  property p_out_nolock;
    sync_oe |-> !locked;
  endproperty
  a_out_nolock: assert property (p_out_nolock) else $error("locked in output mode");
  property p_lock_why;
    $rose(locked) |-> enable && !sync_oe && still_reg < LOSS_CYC;
  endproperty
  a_lock_why: assert property (p_lock_why) else $error("lock without clock");
  property p_loss;
    still_reg > LOSS_CYC + 16 |-> !locked;
  endproperty
  a_loss: assert property (p_loss) else $error("lock kept after loss");
  property p_hold;
    $fell(locked) && enable |-> ##[1:400] $changed(sw_clk);
  endproperty
  a_hold: assert property (p_hold) else $error("switching stopped");
endmodule
bind scs_top scs_top_assertions #(.DW(DW), .LOSS_CYC(LOSS_CYC), .DET_CYC(DET_CYC)) scs_top_assertions_i (
  .clk(clk), .reset(reset), .enable(enable), .sync_in(sync_in), .sync_out(sync_out),
  .sync_oe(sync_oe), .freq_wr(freq_wr), .freq_khz(freq_khz), .div_n_out(div_n_out),
  .freq_rd_khz(freq_rd_khz), .locked(locked), .sw_clk(sw_clk));
`default_nettype wire

// ---- verif/test_switching_clock_select_sync.sv ----
// Self-checking bench for the clock select and sync block
`timescale 1ns/1ns
`default_nettype none
`include "scs_cfg.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_switching_clock_select_sync
  import scs_pkg::*;
;
  localparam int DET = 80;
  logic        clk = 1'b0, reset = 1'b1, enable = 1'b0, freq_wr = 1'b0, run = 1'b0;
  logic [1:0]  cfg = 2'b00, strap = 2'b01;
  logic [4:0]  step = 5'h00;
  logic [10:0] freq_khz = 11'h000, freq_rd_khz;
  logic [5:0]  div_n_out;
  logic        sync_out, sync_oe, locked, sw_clk, src_clk, pin;
  int          fails = 0, checks_done = 0;
  logic [10:0] fk [8] = '{11'h32a, 11'h334, 11'h064, 11'h7d0, 11'h0c8, 11'h3e8, 11'h190,
                          11'h3af};
  logic [5:0]  nx [8] = '{6'h0a, 6'h0a, 6'h28, 6'h08, 6'h28, 6'h08, 6'h14, 6'h09};
  logic [1:0]  st [6] = '{SCS_PIN_LOW, SCS_PIN_OPEN, SCS_PIN_HIGH, SCS_PIN_RES, SCS_PIN_RES,
                          SCS_PIN_RES};
  logic [4:0]  rk [6] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h10, 5'h07};
  logic [5:0]  an [6] = '{6'h28, 6'h14, 6'h08, 6'h28, 6'h08, 6'h14};
  ////////////////////////////////////////
  // Shared pin: the block wins while it drives, else the far source
  assign pin = sync_oe ? sync_out : src_clk;
  always #4 clk = ~clk;
  scs_top #(.DW(6), .LOSS_CYC(40), .DET_CYC(DET)) scs_top_i (.clk(clk), .reset(reset),
    .cfg_strap(cfg), .sync_strap(strap), .res_step(step), .enable(enable), .sync_in(pin),
    .sync_out(sync_out), .sync_oe(sync_oe), .freq_wr(freq_wr), .freq_khz(freq_khz),
    .div_n_out(div_n_out), .freq_rd_khz(freq_rd_khz), .locked(locked), .sw_clk(sw_clk));
  scs_src_model scs_src_model_i (.run(run), .clk_out(src_clk));
  task automatic end_of_test;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Straps settle during reset since the block syncs them through two flops
  task automatic do_reset(input logic [1:0] c, input logic [1:0] s, input logic [4:0] k);
    @(negedge clk);
    reset = 1'b1;
    enable = 1'b0;
    cfg = c;
    strap = s;
    step = k;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_lock(input logic v, input int n);
    for (int i = 0; i < n && locked !== v; i++) @(negedge clk);
  endtask
  task automatic tog(input logic o);
    logic s;
    s = o ? sync_out : sw_clk;
    for (int i = 0; i < 400 && (o ? sync_out : sw_clk) === s; i++) @(negedge clk);
    `CHK(o ? sync_out : sw_clk, ~s)
  endtask
  task automatic t_bus;
    for (int i = 0; i < 8; i++) begin
      freq_wr = 1'b1;
      freq_khz = fk[i];
      @(negedge clk);
      freq_wr = 1'b0;
      @(negedge clk);
      `CHK(div_n_out, nx[i])
      `CHK(freq_rd_khz, 11'((`SCS_BASE_HZ / 1000 + nx[i] / 2) / nx[i]))
    end
    freq_wr = 1'b1;
    freq_khz = 11'h32a;
    @(negedge clk);
    freq_khz = 11'h7d0;
    @(negedge clk);
    freq_wr = 1'b0;
    @(negedge clk);
    `CHK(div_n_out, 6'h08)
  endtask
  task automatic t_input;
    for (int j = 0; j < 2; j++) begin
      run = 1'b1;
      repeat (10) @(negedge clk);
      enable = 1'b1;
      wait_lock(1'b1, 200);
      `CHK(locked, 1'b1)
      run = 1'b0;
      wait_lock(1'b0, 60);
      `CHK(locked, 1'b0)
      // Bench source is faster than the range, so the held divisor is the floor
      `CHK(div_n_out, 6'h08)
      tog(1'b0);
      enable = 1'b0;
      repeat (10) @(negedge clk);
    end
  endtask
  task automatic t_out;
    do_reset(SCS_CFG_OUT, SCS_PIN_OPEN, 5'h00);
    enable = 1'b1;
    repeat (DET + 40) @(negedge clk);
    `CHK(sync_oe, 1'b1)
    tog(1'b1);
    `CHK(locked, 1'b0)
    freq_wr = 1'b1;
    freq_khz = 11'h3e8;
    @(negedge clk);
    freq_wr = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(div_n_out, 6'h14)
  endtask
  task automatic t_auto;
    for (int i = 0; i < 6; i++) begin
      do_reset(SCS_CFG_AUTO, st[i], rk[i]);
      enable = 1'b1;
      repeat (DET + 40) @(negedge clk);
      `CHK(div_n_out, an[i])
      `CHK(locked, 1'b0)
      strap = (st[i] == SCS_PIN_HIGH) ? SCS_PIN_LOW : SCS_PIN_HIGH;
      step = 5'h10 - step;
      repeat (20) @(negedge clk);
      `CHK(div_n_out, an[i])
    end
    do_reset(SCS_CFG_AUTO, SCS_PIN_OPEN, 5'h00);
    run = 1'b1;
    repeat (10) @(negedge clk);
    enable = 1'b1;
    wait_lock(1'b1, 200);
    `CHK(locked, 1'b1)
    run = 1'b0;
  endtask
  ////////////////////////////////////////
  // Main sequence, reset values first
  initial begin
    do_reset(SCS_CFG_IN, SCS_PIN_OPEN, 5'h00);
    `CHK(div_n_out, 6'h14)
    `CHK(freq_rd_khz, 11'h190)
    t_bus;
    t_input;
    t_out;
    t_auto;
    end_of_test;
  end
  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    #200000;
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
